// file: hw/rhsx_map.svh
`ifndef RHSX_MAP_SVH
`define RHSX_MAP_SVH
// Reset pulse: at least 20 us at 100 MHz, rounded up
`define RHSX_CLK_MHZ 100
`define RHSX_PULSE_US 20
`define RHSX_PULSE_CYC (`RHSX_PULSE_US * `RHSX_CLK_MHZ)
// Oscillator settle time in clock cycles
`define RHSX_SETTLE_CYC 16'h0400
// Reset-source flag positions
`define RHSX_F_PIN 0
`define RHSX_F_WWD 1
`define RHSX_F_IWD 2
`define RHSX_F_SW 3
`define RHSX_F_LP 4
`define RHSX_F_OPT 5
`define RHSX_F_PWR 6
`define RHSX_NFLAGS 7
`endif

// file: hw/rhsx_pkg.sv
package rhsx_pkg;
  typedef enum logic [1:0] {
    RHSX_IDLE = 2'b00,
    RHSX_PULSE = 2'b01,
    RHSX_HOLD = 2'b10
  } rhsx_state_t;
  typedef struct packed {
    logic core_reset_request;
    logic window_watchdog;
    logic independent_watchdog;
    logic standby_req;
    logic stop_req;
    logic option_load_trigger;
  } rhsx_src_t;
  typedef struct packed {
    logic fast_ext_osc_enable;
    logic fast_ext_bypass_sel;
    logic ready_irq_enable;
  } rhsx_hse_cfg_t;
endpackage : rhsx_pkg

// file: hw/rhsx_sync.sv
`timescale 1ns/10ps
module rhsx_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rhsx_sync

// file: hw/rhsx_top.sv
// What this block does
// - Any pin low, watchdog, software, low-power, option-load or power event resets system.
// - System reset clears everything except reset-source flags, which record the cause.
// - Core reset request bit written to one causes a system reset.
// - Standby or stop entry with its reset option cleared resets instead.
// - Option-load trigger bit set by software causes a system reset.
// - Internal sources drive reset pin low at least 20 us; external pulls directly.
// - System reset stays asserted for the whole time the reset pin is driven low.
// - Power-on, power-down and standby wake-up produce a power reset.
// - Power reset clears all registers including reset-source flags.
// - Domain software-reset bit or power-on reset applies the RTC-domain reset.
// - RTC-domain reset touches only slow oscillator, RTC and its control register.
// - Bypass plus enable takes the fast clock directly from the oscillator input.
// - In crystal mode the enable bit starts or stops the 4-32 MHz oscillator.
// - Ready flag set once stable; fast clock gated until ready.
// - Ready interrupt raised when ready flag sets and interrupt enabled.
`include "rhsx_map.svh"
`timescale 1ns/10ps
module rhsx_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic ext_reset_pin_in,
  output logic ext_reset_pin_out,
  output logic ext_reset_pin_oe,
  input wire rhsx_pkg::rhsx_src_t src,
  input wire logic standby_reset_opt,
  input wire logic stop_reset_opt,
  input wire logic power_on_det,
  input wire logic power_down_det,
  input wire logic standby_wakeup,
  input wire logic domain_sw_reset_bit,
  input wire logic flags_clear,
  input wire rhsx_pkg::rhsx_hse_cfg_t hse_cfg,
  input wire logic osc_stable,
  output logic [`RHSX_NFLAGS-1:0] reset_flags,
  output logic sys_reset,
  output logic power_reset,
  output logic rtc_domain_reset,
  output logic fast_ext_ready_flag,
  output logic fast_clk_gate,
  output logic osc_drive_en,
  output logic fast_ext_irq,
  output logic standby_enter,
  output logic stop_enter
);
  import rhsx_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic pin_sync;
  logic stable_sync;
  // Pin and stable flag are async: two flops before any logic reads them

  rhsx_sync u_pin_sync (
    .clock(clock),
    .rst(rst),
    .async_in(ext_reset_pin_in),
    .sync_out(pin_sync)
  );

  rhsx_sync u_stable_sync (
    .clock(clock),
    .rst(rst),
    .async_in(osc_stable),
    .sync_out(stable_sync)
  );

  // ****************************************
  // Reset sources
  // ****************************************
  logic pwr_evt;
  logic lp_evt;
  logic int_evt;
  logic ext_evt;
  logic [`RHSX_NFLAGS-1:0] evt_vec;

  assign pwr_evt = power_on_det | power_down_det | standby_wakeup;
  assign lp_evt = (src.standby_req & ~standby_reset_opt) | (src.stop_req & ~stop_reset_opt);
  assign ext_evt = ~pin_sync;
  always_comb begin
    evt_vec = '0;
    evt_vec[`RHSX_F_PIN] = ext_evt;
    evt_vec[`RHSX_F_WWD] = src.window_watchdog;
    evt_vec[`RHSX_F_IWD] = src.independent_watchdog;
    evt_vec[`RHSX_F_SW] = src.core_reset_request;
    evt_vec[`RHSX_F_LP] = lp_evt;
    evt_vec[`RHSX_F_OPT] = src.option_load_trigger;
    evt_vec[`RHSX_F_PWR] = pwr_evt;
  end
  assign int_evt = |evt_vec[`RHSX_NFLAGS-1:1];

  // ****************************************
  // Low-power entry pass-through
  // ****************************************
  // A refused entry becomes a reset instead
  always_ff @(posedge clock) begin
    if (rst) begin
      standby_enter <= 1'b0;
    end else begin
      // Entry only when the option bit lets it through
      standby_enter <= src.standby_req & standby_reset_opt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stop_enter <= 1'b0;
    end else begin
      stop_enter <= src.stop_req & stop_reset_opt;
    end
  end

  // ****************************************
  // Reset pulse sequencer
  // ****************************************
  localparam int PULSE_W = $clog2(`RHSX_PULSE_CYC + 1);
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(`RHSX_PULSE_CYC - 1);
  rhsx_state_t state_reg;
  logic [PULSE_W-1:0] pulse_cnt_reg;
  // A source still high restarts the count, so overlaps stretch the pulse

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= RHSX_PULSE;
      pulse_cnt_reg <= '0;
    end else begin
      case (state_reg)
        RHSX_IDLE: begin
          if (int_evt) begin
            state_reg <= RHSX_PULSE;
            pulse_cnt_reg <= '0;
          end else if (ext_evt) begin
            state_reg <= RHSX_HOLD;
          end
        end
        RHSX_PULSE: begin
          if (int_evt) begin
            pulse_cnt_reg <= '0;
          end else if (pulse_cnt_reg == PULSE_LAST) begin
            state_reg <= ext_evt ? RHSX_HOLD : RHSX_IDLE;
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
          end
        end
        RHSX_HOLD: begin
          if (int_evt) begin
            state_reg <= RHSX_PULSE;
            pulse_cnt_reg <= '0;
          end else if (!ext_evt) begin
            state_reg <= RHSX_IDLE;
          end
        end
        default: begin
          state_reg <= RHSX_PULSE;
        end
      endcase
    end
  end

  // Pin is open-drain: drive low only during an internal pulse
  // Reset holds the pin low until the first pulse ends
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_reset_pin_oe <= 1'b1;
    end else begin
      ext_reset_pin_oe <= (state_reg == RHSX_PULSE) | int_evt;
    end
  end

  // Only ever pulled low, never driven high
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_reset_pin_out <= 1'b0;
    end else begin
      ext_reset_pin_out <= 1'b0;
    end
  end

  // Released one edge after the sequencer returns to idle, synchronously
  always_ff @(posedge clock) begin
    if (rst) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (state_reg != RHSX_IDLE) | int_evt | ext_evt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      power_reset <= 1'b1;
    end else begin
      power_reset <= pwr_evt;
    end
  end

  // ****************************************
  // Reset-source flags
  // ****************************************
  // Kept across a system reset; only rst, a power event or flags_clear wipes them
  logic [`RHSX_NFLAGS-1:0] flags_next;
  // Set beats flags_clear in the same cycle; a power event beats both and leaves only the power flag set
  for (genvar f = 0; f < `RHSX_NFLAGS; f++) begin : g_flag
    always_comb begin
      if (pwr_evt) begin
        flags_next[f] = (f == `RHSX_F_PWR);
      end else if (evt_vec[f]) begin
        flags_next[f] = 1'b1;
      end else if (flags_clear) begin
        flags_next[f] = 1'b0;
      end else begin
        flags_next[f] = reset_flags[f];
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        reset_flags[f] <= 1'b0;
      end else begin
        reset_flags[f] <= flags_next[f];
      end
    end
  end

  // ****************************************
  // RTC domain reset
  // ****************************************
  // Fans out only to slow oscillator, RTC and its control register
  logic rtc_evt;
  assign rtc_evt = domain_sw_reset_bit | power_on_det;
  always_ff @(posedge clock) begin
    if (rst) begin
      rtc_domain_reset <= 1'b1;
    end else begin
      rtc_domain_reset <= rtc_evt;
    end
  end

  // ****************************************
  // Fast external oscillator
  // ****************************************
  logic [15:0] settle_cnt_reg;
  logic ready_next;
  logic bypass_on;
  logic settle_done;

  assign bypass_on = hse_cfg.fast_ext_osc_enable & hse_cfg.fast_ext_bypass_sel;
  // Fixed settle count; a slow resonator may need a longer one
  assign settle_done = (settle_cnt_reg == `RHSX_SETTLE_CYC);
  // Bypass source must itself be clean; no duty check here
  assign ready_next = hse_cfg.fast_ext_osc_enable & stable_sync & settle_done;

  // Any drop of enable or stability restarts the wait
  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      settle_cnt_reg <= 16'h0000;
    end else if (!hse_cfg.fast_ext_osc_enable || !stable_sync) begin
      settle_cnt_reg <= 16'h0000;
    end else if (!settle_done) begin
      settle_cnt_reg <= settle_cnt_reg + 16'h0001;
    end
  end

  // Amplifier off in bypass so the input pin is used directly
  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      osc_drive_en <= 1'b0;
    end else begin
      osc_drive_en <= hse_cfg.fast_ext_osc_enable & ~bypass_on;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      fast_ext_ready_flag <= 1'b0;
    end else begin
      fast_ext_ready_flag <= ready_next;
    end
  end

  // Consumers see no clock until ready
  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      fast_clk_gate <= 1'b0;
    end else begin
      fast_clk_gate <= ready_next;
    end
  end

  // One-cycle pulse only on the rising edge of ready
  always_ff @(posedge clock) begin
    if (rst || sys_reset) begin
      fast_ext_irq <= 1'b0;
    end else begin
      fast_ext_irq <= ready_next & ~fast_ext_ready_flag & hse_cfg.ready_irq_enable;
    end
  end
endmodule : rhsx_top

// file: testbench/rhsx_properties.sv
`timescale 1ns/10ps
`include "rhsx_map.svh"
module rhsx_checker (
  input wire logic clock,
  input wire logic rst,
  input wire rhsx_pkg::rhsx_src_t src,
  input wire logic standby_reset_opt,
  input wire logic stop_reset_opt,
  input wire logic power_on_det,
  input wire logic power_down_det,
  input wire logic standby_wakeup,
  input wire logic domain_sw_reset_bit,
  input wire logic flags_clear,
  input wire rhsx_pkg::rhsx_hse_cfg_t hse_cfg,
  input wire logic ext_reset_pin_in,
  input wire logic ext_reset_pin_oe,
  input wire logic [`RHSX_NFLAGS-1:0] reset_flags,
  input wire logic sys_reset,
  input wire logic power_reset,
  input wire logic rtc_domain_reset,
  input wire logic fast_ext_ready_flag,
  input wire logic fast_ext_irq
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire pw = power_on_det | power_down_det | standby_wakeup;
  wire trig = pw | (|src[5:3]) | src[0] | (src[2] & ~standby_reset_opt) | (src[1] & ~stop_reset_opt);
  logic [15:0] oe_cnt_reg;
  always_ff @(posedge clock) begin
    oe_cnt_reg <= (!rst && ext_reset_pin_oe) ? oe_cnt_reg + 16'h0001 : 16'h0000;
  end
  sequence s_pin_low;
    !ext_reset_pin_in [*3];
  endsequence
  property p_src; trig |=> ext_reset_pin_oe && sys_reset; endproperty
  a_src: assert property (p_src) else $error("no reset after source");
  property p_keep; !flags_clear && !pw |=> (reset_flags & $past(reset_flags)) == $past(reset_flags); endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_pwr; pw |=> power_reset && reset_flags[`RHSX_F_PWR]; endproperty
  a_pwr: assert property (p_pwr) else $error("no power reset");
  property p_rtc; 1'b1 |=> rtc_domain_reset == $past(domain_sw_reset_bit || power_on_det); endproperty
  a_rtc: assert property (p_rtc) else $error("domain reset wrong");
  property p_len; $fell(ext_reset_pin_oe) |-> oe_cnt_reg >= `RHSX_PULSE_CYC; endproperty
  a_len: assert property (p_len) else $error("pulse short");
  property p_hold; ext_reset_pin_oe |-> sys_reset; endproperty
  a_hold: assert property (p_hold) else $error("reset dropped early");
  property p_pin; s_pin_low |=> sys_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin low ignored");
  property p_irq; fast_ext_irq |-> $rose(fast_ext_ready_flag) && $past(hse_cfg.ready_irq_enable); endproperty
  a_irq: assert property (p_irq) else $error("stray ready irq");
endmodule : rhsx_checker
bind rhsx_top rhsx_checker chk_u (.*);

// file: testbench/rhsx_partner.sv
`timescale 1ns/10ps
module rhsx_partner (
  input wire logic clock,
  input wire logic ext_reset_pin_oe,
  input wire logic ext_reset_pin_out,
  input wire logic ext_low,
  input wire logic osc_on,
  output logic ext_reset_pin_in,
  output logic osc_stable
);
  int unsigned run_reg;
  // Pull-up wins unless someone pulls low
  assign ext_reset_pin_in = !((ext_reset_pin_oe && !ext_reset_pin_out) || ext_low);
  // Not stable until start-up delay passes
  always_ff @(posedge clock) begin
    run_reg <= osc_on ? run_reg + 1 : 0;
  end
  assign osc_stable = run_reg > 40;
endmodule : rhsx_partner

// file: testbench/test_reset_and_hs_ext_osc_control.sv
`timescale 1ns/10ps
`include "rhsx_map.svh"
module test_reset_and_hs_ext_osc_control;
  logic clock = 1'b0, rst = 1'b1, standby_reset_opt = 1'b1, stop_reset_opt = 1'b1, power_on_det = 1'b0;
  logic power_down_det = 1'b0, standby_wakeup = 1'b0, domain_sw_reset_bit = 1'b0, flags_clear = 1'b0;
  logic ext_low = 1'b0, ext_reset_pin_in, osc_stable, ext_reset_pin_out, ext_reset_pin_oe, sys_reset;
  logic power_reset, rtc_domain_reset, fast_ext_ready_flag, fast_clk_gate, osc_drive_en, fast_ext_irq;
  logic standby_enter, stop_enter;
  logic [`RHSX_NFLAGS-1:0] reset_flags;
  rhsx_pkg::rhsx_src_t src = '0;
  rhsx_pkg::rhsx_hse_cfg_t hse_cfg = '0;
  int failures = 0, checked = 0, cyc = 0, irqs = 0, exp_flags = 0, n;
  int fm[6] = '{5, 4, 4, 2, 1, 3};
  rhsx_top dut_u (.*);
  rhsx_partner part_u (.clock(clock), .ext_reset_pin_oe(ext_reset_pin_oe), .ext_low(ext_low),
    .ext_reset_pin_out(ext_reset_pin_out),
    .osc_on(hse_cfg.fast_ext_osc_enable), .ext_reset_pin_in(ext_reset_pin_in), .osc_stable(osc_stable));
  // ********
  // Helpers
  // ********
  initial begin
    forever #5 clock = ~clock;
  end
  // Ceiling well above the roughly 22k cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (fast_ext_irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rel(input bit long);
    n = 0;
    while (sys_reset !== 1'b0 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({ext_reset_pin_out, sys_reset}, 0, "release");
    if (long) chk(n >= `RHSX_PULSE_CYC, 1, "pulse length");
  endtask : rel
  task automatic fire(input int i, input bit clr);
    @(posedge clock);
    src <= 6'h01 << i;
    flags_clear <= clr;
    {standby_reset_opt, stop_reset_opt} <= 2'b00;
    @(posedge clock);
    src <= '0;
    flags_clear <= 1'b0;
    #1;
    chk(sys_reset, 1, "source reset");
    exp_flags = (clr ? 0 : exp_flags) | (1 << fm[i]) | 1;
    rel(1);
    chk(reset_flags, exp_flags, "flags");
  endtask : fire
  task automatic osc(input logic [2:0] cfg, input logic drive, input int irq_exp);
    int i0;
    i0 = irqs;
    @(posedge clock);
    hse_cfg <= cfg;
    n = 0;
    while (fast_ext_ready_flag !== 1'b1 && n < 1500) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({n >= 1024, fast_clk_gate, osc_drive_en}, {2'b11, drive}, "ready");
    @(posedge clock);
    #1;
    chk(irqs - i0, irq_exp, "ready irq");
    @(posedge clock);
    hse_cfg <= '0;
    @(posedge clock);
    #1;
    chk({fast_ext_ready_flag, fast_clk_gate}, 0, "disable");
  endtask : osc
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // ********
  // Tests
  // ********
  initial begin
    int off;
    void'($urandom(32'h6c49_2db1));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rel(1);
    chk(reset_flags & 7'h3e, 0, "power-level clear");
    off = $urandom % 6;
    for (int k = 0; k < 6; k++) fire((k + off) % 6, k == 0 || $urandom % 2);
    @(posedge clock);
    {standby_reset_opt, stop_reset_opt} <= 2'b11;
    src <= 6'h06;
    @(posedge clock);
    src <= '0;
    #1;
    chk({standby_enter, stop_enter, sys_reset}, 3'b110, "low-power entry");
    for (int j = 0; j < 3; j++) begin
      @(posedge clock);
      {power_on_det, power_down_det, standby_wakeup} <= 3'b100 >> j;
      @(posedge clock);
      {power_on_det, power_down_det, standby_wakeup} <= 3'b000;
      #1;
      chk({power_reset, rtc_domain_reset}, {1'b1, j == 0}, "power event");
      rel(1);
      chk(reset_flags, 7'h41, "power flags");
    end
    @(posedge clock);
    domain_sw_reset_bit <= 1'b1;
    @(posedge clock);
    domain_sw_reset_bit <= 1'b0;
    #1;
    chk({rtc_domain_reset, sys_reset, reset_flags}, {2'b10, 7'h41}, "domain reset");
    $display("test resets finished");
    @(posedge clock);
    ext_low <= 1'b1;
    flags_clear <= 1'b1;
    @(posedge clock);
    flags_clear <= 1'b0;
    repeat (5) @(posedge clock);
    ext_low <= 1'b0;
    #1;
    chk({sys_reset, reset_flags}, {1'b1, 7'h01}, "pin reset");
    rel(0);
    osc(3'b101, 1'b1, 1);
    osc(3'b110, 1'b0, 0);
    $display("test oscillator finished");
    conclude();
  end
endmodule : test_reset_and_hs_ext_osc_control
